// >>> include/cpu_exec_pkg.sv
// constants and carrier types of the compare / skip / branch / bit-set / shift unit
// assumes an 8-bit core whose decode stage supplies operands and the addressed I/O value
// Behaviour
// - compare with carry or immediate sets Z N V C H S, writes no result
// - register bit clear skips next instruction, flags untouched, one to three cycles
// - register bit set skips next one- or two-word instruction (pc plus two or three), flags untouched
// - I/O bit clear skips next instruction, flags untouched, one to three cycles
// - I/O bit set skips next instruction, flags untouched, one to three cycles
// - branch when named status bit set: pc plus offset plus one
// - branch when named status bit clear: one cycle untaken, two taken
// - equal, carry, lower, same-or-higher, minus, plus branches test Z, C, N
// - signed ge branches on N xor V zero, signed lt on one
// - half-carry, transfer bit and overflow branches test H, T, V
// - interrupt enabled / disabled branches test global interrupt flag
// - set I/O bit forces one bit high, others and flags kept, two cycles
// - clear I/O bit forces one bit low, others and flags kept, two cycles
`default_nettype none
package cpu_exec_pkg;
   // ----------------------------------------
   // status register layout
   // ----------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   // ----------------------------------------
   // widths, reset values, cycle counts
   // ----------------------------------------
   localparam int PC_W = 16;
   localparam int IO_ADDR_W = 6;
   localparam int OFFSET_W = 7;
   localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;
   // ----------------------------------------
   // operations
   // ----------------------------------------
   typedef enum logic [5:0] {
      compare_with_carry, compare_immediate,
      skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set,
      branch_status_bit_set, branch_status_bit_clear,
      branch_equal, branch_not_equal, branch_carry_set, branch_carry_clear,
      branch_same_or_higher, branch_lower, branch_minus, branch_plus,
      branch_signed_ge, branch_signed_lt,
      branch_half_carry_set, branch_half_carry_clear,
      branch_transfer_bit_set, branch_transfer_bit_clear,
      branch_overflow_set, branch_overflow_clear,
      branch_irq_enabled, branch_irq_disabled,
      set_io_bit, clear_io_bit, shift_left_logical, shift_right_logical
   } op_t;
   typedef struct packed {
      op_t op;
      logic [7:0] rd_val;
      logic [7:0] rr_val;
      logic [7:0] imm;
      logic [7:0] io_val;
      logic [IO_ADDR_W-1:0] io_addr;
      logic [2:0] bit_sel;
      logic [OFFSET_W-1:0] offset;
      logic next_two_word;
      logic [PC_W-1:0] pc;
      logic [7:0] status;
   } exec_req_t;
   typedef struct packed {
      logic [PC_W-1:0] pc_next;
      logic pc_load;
      logic [7:0] status;
      logic status_we;
      logic [7:0] result;
      logic result_we;
      logic [IO_ADDR_W-1:0] io_addr;
      logic [7:0] io_wdata;
      logic io_we;
   } exec_res_t;
endpackage
`default_nettype wire

// >>> rtl/cpu_exec_unit.sv
// execution unit for compares, skips, relative branches, I/O bit writes and logical shifts
// assumes decode supplies operands, current status and the addressed I/O value with each request
// clock enable low freezes all state; write strobes only stand with done_out
`timescale 1ns/1ps
`default_nettype none
module cpu_exec_unit (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   input wire logic req_valid_in,
   input wire cpu_exec_pkg::exec_req_t req_in,
   output logic req_ready_out,
   output logic done_out,
   output cpu_exec_pkg::exec_res_t res_out
);
   // ----------------------------------------
   // state and working signals
   // ----------------------------------------
   localparam int PC_W_L = cpu_exec_pkg::PC_W;
   typedef enum {st_idle, st_wait} state_t;

   state_t state_q, state_d;
   logic [1:0] cnt_q, cnt_d;
   logic done_q, done_d;
   cpu_exec_pkg::exec_res_t res_q, res_d;

   logic [7:0] s;
   logic [7:0] d;
   logic [7:0] r;
   logic [7:0] diff;
   logic [7:0] shl;
   logic [7:0] shr;
   logic [PC_W_L-1:0] pc_plus1;
   logic [PC_W_L-1:0] pc_branch;
   logic [PC_W_L-1:0] pc_skip;
   logic cond_bit;
   logic is_branch;
   logic is_skip;
   logic test_val;
   logic [1:0] cycles;
   logic take;

   // ----------------------------------------
   // operand arithmetic
   // ----------------------------------------
   assign take = (state_q == st_idle) && req_valid_in;
   assign s = req_in.status;
   assign d = req_in.rd_val;
   assign r = (req_in.op == cpu_exec_pkg::compare_immediate) ? req_in.imm : req_in.rr_val;
   // carry only enters the compare-with-carry form
   assign diff = d - r - {7'h00, (req_in.op == cpu_exec_pkg::compare_with_carry) & s[cpu_exec_pkg::FLAG_C]};
   assign shl = {d[6:0], 1'b0};
   assign shr = {1'b0, d[7:1]};
   assign pc_plus1 = req_in.pc + 16'h0001;
   // offset sign-extended; counts words like the program counter
   assign pc_branch = pc_plus1 + {{(PC_W_L-cpu_exec_pkg::OFFSET_W){req_in.offset[cpu_exec_pkg::OFFSET_W-1]}},
      req_in.offset};
   assign pc_skip = req_in.next_two_word ? req_in.pc + 16'h0003 : req_in.pc + 16'h0002;

   // ----------------------------------------
   // condition selection
   // ----------------------------------------
   // cond_bit is the flag level that takes the branch
   always_comb begin
      is_branch = 1'b1;
      is_skip = 1'b0;
      test_val = 1'b0;
      cond_bit = 1'b0;
      case (req_in.op)
         cpu_exec_pkg::skip_reg_bit_clear: begin
            is_branch = 1'b0;
            is_skip = ~d[req_in.bit_sel];
         end
         cpu_exec_pkg::skip_reg_bit_set: begin
            is_branch = 1'b0;
            is_skip = d[req_in.bit_sel];
         end
         cpu_exec_pkg::skip_io_bit_clear: begin
            is_branch = 1'b0;
            is_skip = ~req_in.io_val[req_in.bit_sel];
         end
         cpu_exec_pkg::skip_io_bit_set: begin
            is_branch = 1'b0;
            is_skip = req_in.io_val[req_in.bit_sel];
         end
         cpu_exec_pkg::branch_status_bit_set: begin
            test_val = s[req_in.bit_sel];
            cond_bit = 1'b1;
         end
         cpu_exec_pkg::branch_status_bit_clear: begin
            test_val = s[req_in.bit_sel];
         end
         cpu_exec_pkg::branch_equal: begin
            test_val = s[cpu_exec_pkg::FLAG_Z];
            cond_bit = 1'b1;
         end
         cpu_exec_pkg::branch_not_equal: begin
            test_val = s[cpu_exec_pkg::FLAG_Z];
         end
         cpu_exec_pkg::branch_carry_set, cpu_exec_pkg::branch_lower: begin
            test_val = s[cpu_exec_pkg::FLAG_C];
            cond_bit = 1'b1;
         end
         cpu_exec_pkg::branch_carry_clear, cpu_exec_pkg::branch_same_or_higher: begin
            test_val = s[cpu_exec_pkg::FLAG_C];
         end
         cpu_exec_pkg::branch_minus: begin
            test_val = s[cpu_exec_pkg::FLAG_N];
            cond_bit = 1'b1;
         end
         cpu_exec_pkg::branch_plus: begin
            test_val = s[cpu_exec_pkg::FLAG_N];
         end
         cpu_exec_pkg::branch_signed_ge: begin
            test_val = s[cpu_exec_pkg::FLAG_N] ^ s[cpu_exec_pkg::FLAG_V];
         end
         cpu_exec_pkg::branch_signed_lt: begin
            test_val = s[cpu_exec_pkg::FLAG_N] ^ s[cpu_exec_pkg::FLAG_V];
            cond_bit = 1'b1;
         end
         cpu_exec_pkg::branch_half_carry_set: begin
            test_val = s[cpu_exec_pkg::FLAG_H];
            cond_bit = 1'b1;
         end
         cpu_exec_pkg::branch_half_carry_clear: begin
            test_val = s[cpu_exec_pkg::FLAG_H];
         end
         cpu_exec_pkg::branch_transfer_bit_set: begin
            test_val = s[cpu_exec_pkg::FLAG_T];
            cond_bit = 1'b1;
         end
         cpu_exec_pkg::branch_transfer_bit_clear: begin
            test_val = s[cpu_exec_pkg::FLAG_T];
         end
         cpu_exec_pkg::branch_overflow_set: begin
            test_val = s[cpu_exec_pkg::FLAG_V];
            cond_bit = 1'b1;
         end
         cpu_exec_pkg::branch_overflow_clear: begin
            test_val = s[cpu_exec_pkg::FLAG_V];
         end
         cpu_exec_pkg::branch_irq_enabled: begin
            test_val = s[cpu_exec_pkg::FLAG_I];
            cond_bit = 1'b1;
         end
         cpu_exec_pkg::branch_irq_disabled: begin
            test_val = s[cpu_exec_pkg::FLAG_I];
         end
         default: begin
            is_branch = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // per-operation result
   // ----------------------------------------
   always_comb begin
      logic [7:0] fl;
      fl = s;
      res_d = res_q;
      res_d.status_we = 1'b0;
      res_d.result_we = 1'b0;
      res_d.io_we = 1'b0;
      // untaken ops still advance by one word
      res_d.pc_load = 1'b1;
      res_d.pc_next = pc_plus1;
      res_d.status = s;
      res_d.result = d;
      res_d.io_addr = req_in.io_addr;
      res_d.io_wdata = req_in.io_val;
      // one cycle unless a branch, skip or I/O write needs more
      cycles = cpu_exec_pkg::CYC_ONE;
      case (req_in.op)
         cpu_exec_pkg::compare_with_carry, cpu_exec_pkg::compare_immediate: begin
            // borrow form: C and H set when the subtract borrows
            fl[cpu_exec_pkg::FLAG_H] = (~d[3] & r[3]) | (r[3] & diff[3]) | (diff[3] & ~d[3]);
            fl[cpu_exec_pkg::FLAG_V] = (d[7] & ~r[7] & ~diff[7]) | (~d[7] & r[7] & diff[7]);
            fl[cpu_exec_pkg::FLAG_N] = diff[7];
            fl[cpu_exec_pkg::FLAG_C] = (~d[7] & r[7]) | (r[7] & diff[7]) | (diff[7] & ~d[7]);
            // with carry, zero only survives a chain of zero bytes
            fl[cpu_exec_pkg::FLAG_Z] = (diff == 8'h00) &
               ((req_in.op == cpu_exec_pkg::compare_immediate) | s[cpu_exec_pkg::FLAG_Z]);
            fl[cpu_exec_pkg::FLAG_S] = fl[cpu_exec_pkg::FLAG_N] ^ fl[cpu_exec_pkg::FLAG_V];
            res_d.status = fl;
            res_d.status_we = 1'b1;
         end
         cpu_exec_pkg::shift_left_logical, cpu_exec_pkg::shift_right_logical: begin
            if (req_in.op == cpu_exec_pkg::shift_left_logical) begin
               res_d.result = shl;
               fl[cpu_exec_pkg::FLAG_C] = d[7];
               fl[cpu_exec_pkg::FLAG_H] = d[3];
            end else begin
               // half-carry left as it was
               res_d.result = shr;
               fl[cpu_exec_pkg::FLAG_C] = d[0];
            end
            fl[cpu_exec_pkg::FLAG_N] = res_d.result[7];
            fl[cpu_exec_pkg::FLAG_Z] = (res_d.result == 8'h00);
            fl[cpu_exec_pkg::FLAG_V] = fl[cpu_exec_pkg::FLAG_N] ^ fl[cpu_exec_pkg::FLAG_C];
            fl[cpu_exec_pkg::FLAG_S] = fl[cpu_exec_pkg::FLAG_N] ^ fl[cpu_exec_pkg::FLAG_V];
            res_d.status = fl;
            res_d.status_we = 1'b1;
            res_d.result_we = 1'b1;
         end
         cpu_exec_pkg::set_io_bit: begin
            res_d.io_wdata[req_in.bit_sel] = 1'b1;
            res_d.io_we = 1'b1;
            cycles = cpu_exec_pkg::CYC_TWO;
         end
         cpu_exec_pkg::clear_io_bit: begin
            res_d.io_wdata[req_in.bit_sel] = 1'b0;
            res_d.io_we = 1'b1;
            cycles = cpu_exec_pkg::CYC_TWO;
         end
         default: begin
            // skips and branches: program counter only, flags left alone
            if (is_branch && (test_val == cond_bit)) begin
               res_d.pc_next = pc_branch;
               cycles = cpu_exec_pkg::CYC_TWO;
            end else if (is_skip) begin
               res_d.pc_next = pc_skip;
               // one extra cycle per word passed over
               cycles = req_in.next_two_word ? cpu_exec_pkg::CYC_THREE : cpu_exec_pkg::CYC_TWO;
            end
         end
      endcase
      // stored result only changes when an operation is taken
      if (!take) begin
         res_d = res_q;
      end
   end

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   // results are latched at acceptance and only qualified once the last cycle ends
   // cnt_q counts the cycles still owed after the second one
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      done_d = 1'b0;
      case (state_q)
         st_idle: begin
            if (req_valid_in) begin
               if (cycles == cpu_exec_pkg::CYC_ONE) begin
                  done_d = 1'b1;
               end else begin
                  state_d = st_wait;
                  cnt_d = cycles - cpu_exec_pkg::CYC_TWO;
               end
            end
         end
         st_wait: begin
            if (cnt_q == 2'h0) begin
               done_d = 1'b1;
               state_d = st_idle;
            end else begin
               cnt_d = cnt_q - 2'h1;
            end
         end
         default: begin
            state_d = st_idle;
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // clock enable low freezes every register, outputs included
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= st_idle;
         cnt_q <= 2'h0;
         done_q <= 1'b0;
         res_q <= '0;
      end else if (ce_in) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
         res_q <= res_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // strobes stand with done only; data holds until the next acceptance
   assign req_ready_out = (state_q == st_idle);
   assign done_out = done_q;
   always_comb begin
      res_out = res_q;
      res_out.pc_load = res_q.pc_load & done_q;
      res_out.status_we = res_q.status_we & done_q;
      res_out.result_we = res_q.result_we & done_q;
      res_out.io_we = res_q.io_we & done_q;
   end
endmodule
`default_nettype wire

// >>> tb/cpu_exec_assertions.sv
// port-level checks of the execution unit
// assumes binding into the unit; checks stand down while ce_in is low
`timescale 1ns/1ps
`default_nettype none
module cpu_exec_assertions (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   input wire logic req_valid_in,
   input wire cpu_exec_pkg::exec_req_t req_in,
   input wire logic req_ready_out,
   input wire logic done_out,
   input wire cpu_exec_pkg::exec_res_t res_out
);
   // ----------------------------------------
   // shapes
   // ----------------------------------------
   default clocking @(posedge sys_clk_in); endclocking
   // a frozen clock enable stretches every count, so checks stand down
   default disable iff (!reset_n_in || !ce_in);
   logic take;
   cpu_exec_pkg::op_t op;
   assign take = req_valid_in && req_ready_out;
   assign op = req_in.op;
   sequence two_step;
      !done_out ##1 done_out;
   endsequence
   sequence three_step;
      !done_out ##1 two_step;
   endsequence
   property p_io(logic setv);
      take && op == (setv ? cpu_exec_pkg::set_io_bit : cpu_exec_pkg::clear_io_bit)
      |-> ##1 two_step ##0 res_out.io_we && !res_out.status_we
          && res_out.io_wdata == (setv ? $past(req_in.io_val, 2) | (8'h01 << $past(req_in.bit_sel, 2))
             : $past(req_in.io_val, 2) & ~(8'h01 << $past(req_in.bit_sel, 2)));
   endproperty
   property p_shift(logic left);
      take && op == (left ? cpu_exec_pkg::shift_left_logical : cpu_exec_pkg::shift_right_logical)
      |=> done_out && res_out.result_we
          && res_out.result == (left ? {$past(req_in.rd_val[6:0]), 1'b0} : {1'b0, $past(req_in.rd_val[7:1])})
          && res_out.status[0] == (left ? $past(req_in.rd_val[7]) : $past(req_in.rd_val[0]));
   endproperty
   property p_branch;
      take && op == cpu_exec_pkg::branch_status_bit_set && req_in.status[req_in.bit_sel]
      |-> ##1 two_step ##0 res_out.pc_load && !res_out.status_we
          && res_out.pc_next == $past(req_in.pc, 2) + 16'h0001
             + {{9{$past(req_in.offset[6], 2)}}, $past(req_in.offset, 2)};
   endproperty
   property p_skip;
      take && op == cpu_exec_pkg::skip_io_bit_set && req_in.io_val[req_in.bit_sel] && req_in.next_two_word
      |-> ##1 three_step ##0 res_out.pc_next == $past(req_in.pc, 3) + 16'h0003 && !res_out.status_we;
   endproperty
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   cmp_one_cycle_a: assert property (
      take && (op == cpu_exec_pkg::compare_with_carry || op == cpu_exec_pkg::compare_immediate)
      |=> done_out && res_out.status_we && !res_out.result_we) else $error("compare timing wrong");
   cmp_equal_a: assert property (
      take && op == cpu_exec_pkg::compare_immediate && req_in.rd_val == req_in.imm
      |=> res_out.status[1] && !res_out.status[0]) else $error("compare equal flags wrong");
   shift_left_a: assert property (p_shift(1'b1)) else $error("left shift wrong");
   shift_right_a: assert property (p_shift(1'b0)) else $error("right shift wrong");
   io_set_a: assert property (p_io(1'b1)) else $error("io bit set wrong");
   io_clear_a: assert property (p_io(1'b0)) else $error("io bit clear wrong");
   branch_taken_a: assert property (p_branch) else $error("taken branch wrong");
   skip_three_a: assert property (p_skip) else $error("skip over two words wrong");
   signed_lt_idle_a: assert property (
      take && op == cpu_exec_pkg::branch_signed_lt && !(req_in.status[2] ^ req_in.status[3])
      |=> done_out && !res_out.status_we) else $error("untaken signed branch wrong");
   skip_idle_a: assert property (
      take && op == cpu_exec_pkg::skip_reg_bit_set && !req_in.rd_val[req_in.bit_sel]
      && !req_in.rr_val[req_in.bit_sel] |=> done_out) else $error("untaken skip wrong");
endmodule
bind cpu_exec_unit cpu_exec_assertions u_chk (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
   .ce_in(ce_in), .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
   .done_out(done_out), .res_out(res_out));
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench of the execution unit
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic ce_in = 1'b1;
   logic req_valid_in = 1'b0;
   cpu_exec_pkg::exec_req_t req_in = '0;
   cpu_exec_pkg::exec_req_t rq;
   cpu_exec_pkg::exec_res_t res_out;
   cpu_exec_pkg::exec_res_t got;
   logic req_ready_out;
   logic done_out;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc;
   logic busy;
   always #4 sys_clk_in = ~sys_clk_in;
   cpu_exec_unit u_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
      .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
      .done_out(done_out), .res_out(res_out));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic prep(input int o, input logic [7:0] v, input logic [7:0] s);
      rq = '0;
      rq.op = cpu_exec_pkg::op_t'(o);
      rq.rd_val = v;
      rq.rr_val = v;
      rq.io_val = v;
      rq.status = s;
      rq.pc = 16'h0200;
   endtask
   // one request, then count cycles until done; ready is high here
   task automatic issue;
      @(posedge sys_clk_in);
      req_valid_in <= 1'b1;
      req_in <= rq;
      @(posedge sys_clk_in);
      req_valid_in <= 1'b0;
      cyc = 1;
      #1;
      busy = !req_ready_out;
      while (done_out !== 1'b1 && cyc < 16) begin
         @(posedge sys_clk_in);
         #1;
         cyc++;
      end
      got = res_out;
      chk(busy, cyc > 1, "ready while busy");
      if (done_out !== 1'b1) begin
         fail_count++;
         $display("BAD %0t no done", $time);
         tally_and_finish;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_compare;
      logic [7:0] a[4] = '{8'h10, 8'h10, 8'h00, 8'h80};
      logic [7:0] b[4] = '{8'h10, 8'h0f, 8'h01, 8'h01};
      logic [7:0] s[4] = '{8'h02, 8'h01, 8'hc0, 8'h00};
      logic [7:0] r;
      logic [7:0] f;
      logic ci;
      int i;
      for (int k = 0; k < 8; k++) begin
         i = k / 2;
         prep(k % 2, a[i], s[i]);
         rq.rr_val = b[i];
         rq.imm = b[i];
         ci = (k % 2 == 0) ? s[i][0] : 1'b0;
         r = a[i] - b[i] - ci;
         f = s[i];
         f[5] = (!a[i][3] & b[i][3]) | (b[i][3] & r[3]) | (r[3] & !a[i][3]);
         f[3] = (a[i][7] & !b[i][7] & !r[7]) | (!a[i][7] & b[i][7] & r[7]);
         f[2] = r[7];
         f[1] = (r == 8'h00) && (k % 2 == 1 || s[i][1]);
         f[0] = (!a[i][7] & b[i][7]) | (b[i][7] & r[7]) | (r[7] & !a[i][7]);
         f[4] = f[2] ^ f[3];
         issue;
         chk(cyc, 1, "cmp cycles");
         chk(got.status, f, "cmp flags");
         chk({got.status_we, got.result_we, got.io_we}, 3'b100, "cmp writes");
      end
      $display("compare test done");
   endtask
   task automatic test_shift;
      logic [7:0] v[3] = '{8'h81, 8'h48, 8'h01};
      logic [7:0] r;
      logic c;
      logic h;
      for (int k = 0; k < 6; k++) begin
         prep(28 + k % 2, v[k / 2], 8'h60);
         c = (k % 2 == 0) ? v[k / 2][7] : v[k / 2][0];
         h = (k % 2 == 0) ? v[k / 2][3] : 1'b1;
         r = (k % 2 == 0) ? {v[k / 2][6:0], 1'b0} : {1'b0, v[k / 2][7:1]};
         issue;
         chk(cyc, 1, "shift cycles");
         chk(got.result, r, "shift result");
         chk(got.status, {2'b01, h, c, r[7] ^ c, r[7], r == 8'h00, c}, "shift flags");
         chk({got.status_we, got.result_we}, 2'b11, "shift writes");
      end
      $display("shift test done");
   endtask
   task automatic test_skip;
      logic [7:0] m;
      logic sk;
      int n;
      for (int k = 0; k < 16; k++) begin
         m = 8'h01 << 3'(k * 3);
         prep(2 + k % 4, k[2] ? m : ~m, 8'hff);
         rq.bit_sel = 3'(k * 3);
         rq.next_two_word = k[3];
         sk = k[0] ? k[2] : !k[2];
         n = sk ? (k[3] ? 3 : 2) : 1;
         issue;
         chk(cyc, n, "skip cycles");
         chk(got.pc_next, 16'h0200 + n, "skip pc");
         chk({got.pc_load, got.status_we}, 2'b10, "skip writes");
      end
      $display("skip test done");
   endtask
   task automatic test_branch;
      // set form per operation, from status-bit set up to interrupt disabled
      logic [19:0] pol = 20'h55995;
      int fl[9] = '{1, 0, 0, 2, 0, 5, 6, 3, 7};
      logic [7:0] st[4] = '{8'h00, 8'hff, 8'h55, 8'haa};
      logic [7:0] s;
      logic v;
      logic tk;
      int j;
      for (int k = 0; k < 80; k++) begin
         s = st[k % 4];
         j = k / 4 - 2;
         prep(6 + k / 4, 8'h00, s);
         rq.bit_sel = 3'(k);
         rq.offset = k[0] ? 7'h40 : 7'h3f;
         if (k < 8) begin
            v = s[3'(k)];
         end else if (j / 2 == 4) begin
            v = s[2] ^ s[3];
         end else begin
            v = s[fl[j / 2]];
         end
         tk = pol[k / 4] ? v : !v;
         issue;
         chk(cyc, tk ? 2 : 1, "branch cycles");
         chk(got.pc_next, 16'h0201 + (tk ? {{9{rq.offset[6]}}, rq.offset} : 16'h0000),
            "branch pc");
         chk(got.status_we, 1'b0, "branch flags");
      end
      $display("branch test done");
   endtask
   task automatic test_io;
      logic [7:0] m;
      for (int k = 0; k < 16; k++) begin
         m = 8'h01 << (k / 2);
         prep(26 + k % 2, k[1] ? 8'ha5 : 8'h5a, 8'h00);
         rq.io_addr = 6'(k + 8);
         rq.bit_sel = 3'(k / 2);
         issue;
         chk(cyc, 2, "io cycles");
         chk(got.io_wdata, k[0] ? rq.io_val & ~m : rq.io_val | m, "io data");
         chk(got.io_addr, 6'(k + 8), "io addr");
         chk({got.io_we, got.status_we, got.result_we}, 3'b100, "io writes");
      end
      $display("io bit test done");
   endtask
   // clock enable dropped right after acceptance must hold the operation
   task automatic test_freeze;
      prep(26, 8'h00, 8'h00);
      rq.bit_sel = 3'h4;
      @(posedge sys_clk_in);
      req_valid_in <= 1'b1;
      req_in <= rq;
      @(posedge sys_clk_in);
      req_valid_in <= 1'b0;
      ce_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      #1;
      chk({req_ready_out, done_out}, 2'b00, "frozen mid operation");
      @(posedge sys_clk_in);
      ce_in <= 1'b1;
      @(posedge sys_clk_in);
      #1;
      chk({done_out, res_out.io_we, res_out.io_wdata}, 10'h310, "resume after freeze");
      $display("freeze test done");
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      @(posedge sys_clk_in);
      #1;
      chk({req_ready_out, done_out}, 2'b10, "idle after reset");
      test_compare;
      test_shift;
      test_skip;
      test_branch;
      test_io;
      test_freeze;
      tally_and_finish;
   end
endmodule
`default_nettype wire
